// file: core/cspc_pkg.sv
// Package for the configuration status and pin control block.
// Assumes a single 50 MHz clock domain and an AXI4-Lite register port.
package cspc_pkg;
   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_MHZ = 50;
   localparam int WAIT_MIN_US = 30;
   localparam int WAIT_MAX_US = 300;
   localparam int WAIT_MIN_CYC = WAIT_MIN_US * CLK_MHZ;
   localparam int WAIT_MAX_CYC = WAIT_MAX_US * CLK_MHZ;
   localparam int CLEAR_CYC = 64;
   localparam int CNT_W = 16;
   // ----------------------------------------
   // Register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_IRQ = 8'h08;
   localparam logic [7:0] OFF_MASK = 8'h0c;
   localparam logic [7:0] OFF_USER = 8'h10;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTRL_START = 0;
   localparam int CTRL_MASTER = 1;
   localparam int CTRL_DATERR = 2;
   localparam int CTRL_DONE = 3;
   localparam int CTRL_TRIST = 4;
   localparam int CTRL_SETRST = 5;
   localparam int CTRL_SCANPRIM = 6;
   localparam int CTRL_EXTEST = 7;
   localparam int CTRL_GSRSEL = 8;
   localparam int CTRL_GTSSEL = 9;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0002;
   // Interrupt bits
   localparam int IRQ_ACTIVE = 0;
   localparam int IRQ_ERROR = 1;
   localparam int IRQ_INITLOW = 2;
   localparam int IRQ_W = 3;
   // ----------------------------------------
   // Sequencer states
   // ----------------------------------------
   typedef enum logic [2:0] {
      CSPC_CLEAR = 3'b000,
      CSPC_HOLD = 3'b001,
      CSPC_DELAY = 3'b011,
      CSPC_CONFIG = 3'b010,
      CSPC_ACTIVE = 3'b110
   } cspc_state_t;
   // Output and enable pair of an open-drain or two-way pin
   typedef struct packed {
      logic out;
      logic oe;
   } cspc_pin_t;
endpackage

// file: core/cspc_axil.sv
// AXI4-Lite slave front end, one write and one read at a time.
// Assumes the parent decodes the byte address and returns read data.
`timescale 1ns/1ps
`default_nettype none
module cspc_axil (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // AXI4-Lite
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side
   output logic wrEn,
   output logic [7:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   input wire logic wrOk,
   output logic [7:0] rdAddr,
   input wire logic [31:0] rdValue,
   input wire logic rdOk
);
   typedef struct packed {
      logic haveAw;
      logic haveW;
      logic [7:0] aw;
      logic [31:0] w;
      logic [3:0] s;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [31:0] rd;
      logic [1:0] rr;
   } cspc_bus_t;
   cspc_bus_t st, next_st;
   always_comb begin
      next_st = st;
      if (awvalid && awready) begin
         next_st.haveAw = 1'b1;
         next_st.aw = awaddr;
      end
      if (wvalid && wready) begin
         next_st.haveW = 1'b1;
         next_st.w = wdata;
         next_st.s = wstrb;
      end
      if (st.haveAw && st.haveW) begin
         next_st.haveAw = 1'b0;
         next_st.haveW = 1'b0;
         next_st.bv = 1'b1;
         next_st.br = wrOk ? 2'h0 : 2'h2;
      end
      if (bvalid && bready) begin
         next_st.bv = 1'b0;
      end
      if (arvalid && arready) begin
         next_st.rv = 1'b1;
         next_st.rd = rdValue;
         next_st.rr = rdOk ? 2'h0 : 2'h2;
      end else if (rvalid && rready) begin
         next_st.rv = 1'b0;
      end
   end
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
   assign awready = !st.haveAw && !st.bv;
   assign wready = !st.haveW && !st.bv;
   assign arready = !st.rv;
   assign bvalid = st.bv;
   assign bresp = st.br;
   assign rvalid = st.rv;
   assign rdata = st.rd;
   assign rresp = st.rr;
   assign wrEn = st.haveAw && st.haveW;
   assign wrAddr = st.aw;
   assign wrData = st.w;
   assign wrStrb = st.s;
   assign rdAddr = araddr;
endmodule
`default_nettype wire

// file: core/cspc_top.sv
// Configuration status and pin control: indicators, init/error pin,
// global set/reset and three-state nets, test pin gating.
// Assumes synchronous pin inputs and a start-up sequencer behind registers.
//
// Notes on behaviour
// - Unused outputs float, pulled up, before configuration
// - Unused cells become pulled-up inputs afterwards
// - Any user pin may drive global reset
// - Global three-state floats outputs, logic keeps running
// - External test overrides the three-state net
// - High indicator driven high until active
// - Low indicator driven low until active
// - Init pin low during clearing
// - Low init pin holds wait state
// - Master modes wait 30 to 300 us
// - Init pin low flags data error
// - Init pin released once outputs active
// - No scan primitive disables scan afterwards
// - Test inputs come straight from pads once active, held at zero before
// - Buffer pair shares one input
`timescale 1ns/1ps
`default_nettype none
module cspc_top #(
   parameter int NUM_IO = 8,
   parameter int WAIT_CYC = cspc_pkg::WAIT_MIN_CYC + 100
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // AXI4-Lite
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic irq,
   // Configuration indicators and init/error pin
   output logic highDuringConfigOut,
   output logic highDuringConfigOe,
   output logic lowDuringConfigOut,
   output logic lowDuringConfigOe,
   input wire logic initErrIn,
   output logic initErrOut,
   output logic initErrOe,
   // User I/O cells
   input wire logic [NUM_IO-1:0] ioIn,
   input wire logic [NUM_IO-1:0] userOut,
   input wire logic [NUM_IO-1:0] userOe,
   input wire logic [NUM_IO-1:0] ioUsed,
   output logic [NUM_IO-1:0] ioOut,
   output logic [NUM_IO-1:0] ioOe,
   output logic [NUM_IO-1:0] ioPullup,
   // Global nets
   output logic globalSetResetNet,
   output logic globalTristateNet,
   // Test pins and internal copies
   input wire logic tdiPad,
   input wire logic tckPad,
   input wire logic tmsPad,
   output logic scanEnable,
   output logic [2:0] testPinsToLogic,
   // Global buffer pair
   input wire logic clockPairSrc,
   output logic lowSkewGlobalIn,
   output logic earlyGlobalIn,
   // Status
   output logic configStart,
   output logic ioActive
);
   localparam int WAIT_MIN = cspc_pkg::WAIT_MIN_CYC;
   localparam int WAIT_MAX = cspc_pkg::WAIT_MAX_CYC;
   localparam int WAIT_USE = (WAIT_CYC < WAIT_MIN) ? WAIT_MIN :
                             (WAIT_CYC > WAIT_MAX) ? WAIT_MAX : WAIT_CYC;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      cspc_pkg::cspc_state_t fsm;
      logic [cspc_pkg::CNT_W-1:0] cnt;
      logic [31:0] ctrl;
      logic [2:0] gsrPin;
      logic [2:0] gtsPin;
      logic [cspc_pkg::IRQ_W-1:0] irqStat;
      logic [cspc_pkg::IRQ_W-1:0] irqMask;
      logic initSeen;
      logic errPrev;
   } cspc_top_t;
   cspc_top_t st, next_st;

   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrOk;
   logic [7:0] rdAddr;
   logic [31:0] rdValue;
   logic rdOk;

   cspc_axil u_bus (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rdata(rdata),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrOk(wrOk),
      .rdAddr(rdAddr),
      .rdValue(rdValue),
      .rdOk(rdOk)
   );

   logic active;
   logic inConfig;
   logic extest;
   logic gsrSrc;
   logic gtsSrc;
   logic [cspc_pkg::IRQ_W-1:0] events;
   logic [cspc_pkg::IRQ_W-1:0] clearBits;

   assign active = (st.fsm == cspc_pkg::CSPC_ACTIVE);
   assign inConfig = (st.fsm == cspc_pkg::CSPC_CONFIG);
   assign wrOk = (wrAddr == cspc_pkg::OFF_CTRL) || (wrAddr == cspc_pkg::OFF_IRQ) ||
                 (wrAddr == cspc_pkg::OFF_MASK) || (wrAddr == cspc_pkg::OFF_STAT) ||
                 (wrAddr == cspc_pkg::OFF_USER);
   assign clearBits = (wrEn && wrAddr == cspc_pkg::OFF_IRQ && wrStrb[0]) ?
                      wrData[cspc_pkg::IRQ_W-1:0] : '0;
   // Events: outputs go active, data error reported, init held low
   assign events = {inConfig && !initErrIn && !st.initSeen,
                    inConfig && st.ctrl[cspc_pkg::CTRL_DATERR] && !st.errPrev,
                    inConfig && st.ctrl[cspc_pkg::CTRL_DONE] && !st.ctrl[cspc_pkg::CTRL_DATERR]};

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      next_st = st;
      if (wrEn && wrAddr == cspc_pkg::OFF_CTRL) begin
         for (int b = 0; b < 4; b++) begin
            if (wrStrb[b]) begin
               next_st.ctrl[b*8 +: 8] = wrData[b*8 +: 8];
            end
         end
      end
      if (wrEn && wrAddr == cspc_pkg::OFF_MASK && wrStrb[0]) begin
         next_st.irqMask = wrData[cspc_pkg::IRQ_W-1:0];
      end
      if (wrEn && wrAddr == cspc_pkg::OFF_USER && wrStrb[0]) begin
         next_st.gsrPin = wrData[2:0];
         next_st.gtsPin = wrData[10:8];
      end
      // Set wins over a write-one clear
      next_st.irqStat = (st.irqStat & ~clearBits) | events;
      next_st.errPrev = st.ctrl[cspc_pkg::CTRL_DATERR];
      next_st.initSeen = inConfig ? (st.initSeen | !initErrIn) : 1'b0;
      unique case (st.fsm)
         cspc_pkg::CSPC_CLEAR: begin
            if (st.cnt == cspc_pkg::CNT_W'(cspc_pkg::CLEAR_CYC - 1)) begin
               next_st.fsm = cspc_pkg::CSPC_HOLD;
               next_st.cnt = '0;
            end else begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
         cspc_pkg::CSPC_HOLD: begin
            if (initErrIn && st.ctrl[cspc_pkg::CTRL_START]) begin
               next_st.fsm = st.ctrl[cspc_pkg::CTRL_MASTER] ?
                             cspc_pkg::CSPC_DELAY : cspc_pkg::CSPC_CONFIG;
               next_st.cnt = '0;
            end
         end
         cspc_pkg::CSPC_DELAY: begin
            if (!initErrIn) begin
               next_st.fsm = cspc_pkg::CSPC_HOLD;
            end else if (st.cnt == cspc_pkg::CNT_W'(WAIT_USE - 1)) begin
               next_st.fsm = cspc_pkg::CSPC_CONFIG;
               next_st.cnt = '0;
            end else begin
               next_st.cnt = st.cnt + 1'b1;
            end
         end
         cspc_pkg::CSPC_CONFIG: begin
            if (st.ctrl[cspc_pkg::CTRL_DONE] && !st.ctrl[cspc_pkg::CTRL_DATERR]) begin
               next_st.fsm = cspc_pkg::CSPC_ACTIVE;
            end
         end
         cspc_pkg::CSPC_ACTIVE: begin
         end
         default: begin
            next_st.fsm = cspc_pkg::CSPC_CLEAR;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         st <= '{fsm: cspc_pkg::CSPC_CLEAR, cnt: '0, ctrl: cspc_pkg::CTRL_RESET,
                 gsrPin: '0, gtsPin: '0, irqStat: '0, irqMask: '0,
                 initSeen: 1'b0, errPrev: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   always_comb begin
      rdValue = '0;
      rdOk = 1'b1;
      unique case (rdAddr)
         cspc_pkg::OFF_CTRL: rdValue = st.ctrl;
         cspc_pkg::OFF_STAT: rdValue = {24'h0, initErrIn, scanEnable, extest,
                                        globalTristateNet, globalSetResetNet, st.fsm};
         cspc_pkg::OFF_IRQ: rdValue = {29'h0, st.irqStat};
         cspc_pkg::OFF_MASK: rdValue = {29'h0, st.irqMask};
         cspc_pkg::OFF_USER: rdValue = {21'h0, st.gtsPin, 5'h0, st.gsrPin};
         default: rdOk = 1'b0;
      endcase
   end
   assign irq = |(st.irqStat & st.irqMask);

   // ----------------------------------------
   // Configuration pins
   // ----------------------------------------
   // one release event
   assign ioActive = active;
   assign highDuringConfigOut = active ? userOut[0] : 1'b1;
   assign highDuringConfigOe = active ? userOe[0] : 1'b1;
   assign lowDuringConfigOut = active ? userOut[1] : 1'b0;
   assign lowDuringConfigOe = active ? userOe[1] : 1'b1;
   assign initErrOut = active ? userOut[2] : 1'b0;
   assign initErrOe = active ? userOe[2] :
                      (st.fsm == cspc_pkg::CSPC_CLEAR) ||
                      (inConfig && st.ctrl[cspc_pkg::CTRL_DATERR]);
   assign configStart = inConfig;

   // ----------------------------------------
   // Global nets
   // ----------------------------------------
   // any user pin drives reset
   assign gsrSrc = st.ctrl[cspc_pkg::CTRL_GSRSEL] ? ioIn[st.gsrPin % NUM_IO] : 1'b0;
   assign globalSetResetNet = st.ctrl[cspc_pkg::CTRL_SETRST] | gsrSrc;
   assign gtsSrc = st.ctrl[cspc_pkg::CTRL_GTSSEL] ? ioIn[st.gtsPin % NUM_IO] : 1'b0;
   assign globalTristateNet = st.ctrl[cspc_pkg::CTRL_TRIST] | gtsSrc;
   assign scanEnable = !active || st.ctrl[cspc_pkg::CTRL_SCANPRIM];
   assign extest = scanEnable && st.ctrl[cspc_pkg::CTRL_EXTEST];
   assign testPinsToLogic = active ? {tmsPad, tckPad, tdiPad} : 3'h0;
   assign lowSkewGlobalIn = clockPairSrc;
   assign earlyGlobalIn = clockPairSrc;

   // ----------------------------------------
   // User I/O cells
   // ----------------------------------------
   genvar i;
   generate
      for (i = 0; i < NUM_IO; i++) begin : g_io
         always_comb begin
            if (!active) begin
               ioOe[i] = 1'b0;
               ioPullup[i] = 1'b1;
            end else if (!ioUsed[i]) begin
               ioOe[i] = 1'b0;
               ioPullup[i] = 1'b1;
            end else begin
               ioOe[i] = userOe[i] && (!globalTristateNet || extest);
               ioPullup[i] = 1'b0;
            end
            ioOut[i] = active ? userOut[i] : 1'b0;
         end
      end
   endgenerate
endmodule
`default_nettype wire

// file: verification/cspc_top_props.sv
// Checker of the status and pin control top.
// Sees only top ports; bound to every cspc_top below.
`timescale 1ns/1ps
`default_nettype none
module cspc_top_props #(
   parameter int NUM_IO = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Indicator and init pins
   input wire logic highDuringConfigOut,
   input wire logic highDuringConfigOe,
   input wire logic lowDuringConfigOut,
   input wire logic lowDuringConfigOe,
   input wire logic initErrIn,
   input wire logic initErrOut,
   input wire logic initErrOe,
   // User cells
   input wire logic [NUM_IO-1:0] userOut,
   input wire logic [NUM_IO-1:0] userOe,
   input wire logic [NUM_IO-1:0] ioUsed,
   input wire logic [NUM_IO-1:0] ioOe,
   input wire logic [NUM_IO-1:0] ioPullup,
   // Globals and test pins
   input wire logic globalTristateNet,
   input wire logic tdiPad,
   input wire logic tckPad,
   input wire logic tmsPad,
   input wire logic scanEnable,
   input wire logic [2:0] testPinsToLogic,
   input wire logic clockPairSrc,
   input wire logic lowSkewGlobalIn,
   input wire logic earlyGlobalIn,
   input wire logic configStart,
   input wire logic ioActive
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // Cycles since reset; saturates so it never wraps back into clearing
   logic [7:0] since;
   always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) since <= 8'h00;
      else if (since != 8'hff) since <= since + 8'h01;
   end
   sequence s_release;
      !ioActive ##1 ioActive;
   endsequence
   a_hdc_hold: assert property (!ioActive |-> highDuringConfigOut && highDuringConfigOe)
      else $error("high indicator not driven high");
   a_ldc_hold: assert property (!ioActive |-> !lowDuringConfigOut && lowDuringConfigOe)
      else $error("low indicator not driven low");
   a_float_pre: assert property (!ioActive |-> ioOe == '0 && ioPullup == '1)
      else $error("cell driven before active");
   a_unused_pull: assert property (ioActive |-> ioPullup == ~ioUsed && (ioOe & ~ioUsed) == '0)
      else $error("unused cell not pulled-up input");
   a_out_follow: assert property (ioActive && !globalTristateNet |-> ioOe == (userOe & ioUsed))
      else $error("output enable lost without three-state");
   a_clear_pull: assert property (since < 8'h3c |-> initErrOe && !initErrOut)
      else $error("init pin not low while clearing");
   a_wait_pin: assert property ($rose(configStart) |-> $past(initErrIn))
      else $error("configuration began with init low");
   a_init_user: assert property (ioActive |-> initErrOe == userOe[2] && initErrOut == userOut[2])
      else $error("init pin not released to user");
   a_release_same: assert property (s_release |-> highDuringConfigOe == userOe[0] &&
      lowDuringConfigOe == userOe[1] && initErrOe == userOe[2])
      else $error("pins did not switch together");
   a_test_route: assert property (ioActive |-> testPinsToLogic == {tmsPad, tckPad, tdiPad})
      else $error("test pads not routed");
   a_scan_pre: assert property (!ioActive |-> scanEnable && testPinsToLogic == 3'h0)
      else $error("scan off before active");
   a_clock_pair: assert property (lowSkewGlobalIn == clockPairSrc && earlyGlobalIn == clockPairSrc)
      else $error("buffer pair inputs differ");
   a_tristate_float: assert property (ioActive && globalTristateNet && !scanEnable |-> ioOe == '0)
      else $error("cell driven under three-state");
endmodule
bind cspc_top cspc_top_props #(.NUM_IO(NUM_IO)) u_props (.*);
`default_nettype wire

// file: verification/cspc_host_model.sv
// Board host on the open-drain init pin, with the board pull-up.
// Assumes the bench drives holdLow on clock edges.
`timescale 1ns/1ps
`default_nettype none
module cspc_host_model (
   // Device side of the pin
   input wire logic initErrOut,
   input wire logic initErrOe,
   // Host control
   input wire logic holdLow,
   // Resolved wire level
   output logic initErrIn
);
   // host may hold pin low; pull-up wins when nobody drives
   assign initErrIn = (initErrOe ? initErrOut : 1'h1) & ~holdLow;
endmodule
`default_nettype wire

// file: verification/config_status_pin_control_tb.sv
// Self-checking bench of the status and pin control top.
// Assumes the host model on the init pin and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module config_status_pin_control_tb;
   logic clk_sys, resetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
   logic rvalid, rready, irq, highDuringConfigOut, highDuringConfigOe, lowDuringConfigOut;
   logic lowDuringConfigOe, initErrIn, initErrOut, initErrOe, globalSetResetNet, holdLow;
   logic globalTristateNet, tdiPad, tckPad, tmsPad, scanEnable, clockPairSrc, lowSkewGlobalIn;
   logic earlyGlobalIn, configStart, ioActive;
   logic [7:0] awaddr, araddr, ioIn, userOut, userOe, ioUsed, ioOut, ioOe, ioPullup;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [2:0] testPinsToLogic;
   int mismatches, total_checks;
   cspc_top u_cspc_top (.*);
   cspc_host_model u_cspc_host_model (.*);
   initial begin
      clk_sys = 1'h0;
      forever #10 clk_sys = ~clk_sys;
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (awvalid && awready) awvalid <= 1'h0;
         if (wvalid && wready) wvalid <= 1'h0;
         if (bvalid === 1'h1) break;
      end
      bready <= 1'h0;
      check({n < 50, bresp}, {1'h1, er}, "write answer");
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
      int n;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      for (n = 0; n < 50; n++) begin
         @(posedge clk_sys);
         if (arvalid && arready) arvalid <= 1'h0;
         if (rvalid === 1'h1) break;
      end
      rready <= 1'h0;
      d = rdata;
      check({n < 50, rresp}, {1'h1, er}, "read answer");
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_preconfig();
      logic [31:0] d;
      cyc(3);
      check({initErrOe, initErrOut, initErrIn}, 3'h4, "init while clearing");
      check({highDuringConfigOut, highDuringConfigOe, lowDuringConfigOut, lowDuringConfigOe},
         4'hd, "indicators");
      check({ioOe, ioPullup}, 16'h00ff, "cells before active");
      check({scanEnable, testPinsToLogic}, 4'h8, "test pins");
      rd(cspc_pkg::OFF_CTRL, 2'h0, d);
      check(d, cspc_pkg::CTRL_RESET, "control reset value");
      rd(8'h20, 2'h2, d);
      wr(8'h24, 32'h0, 2'h2);
   endtask
   task automatic t_hold_wait();
      int n;
      holdLow <= 1'h1;
      wr(cspc_pkg::OFF_MASK, 32'h7, 2'h0);
      wr(cspc_pkg::OFF_CTRL, 32'h3, 2'h0);
      cyc(200);
      check(configStart, 1'h0, "start while pin held");
      holdLow <= 1'h0;
      for (n = 0; n < 20000 && configStart !== 1'h1; n++) @(posedge clk_sys);
      // Window of 30 to 300 us at 50 MHz
      check(n >= cspc_pkg::WAIT_MIN_CYC && n <= cspc_pkg::WAIT_MAX_CYC, 1'h1, "master wait");
   endtask
   task automatic t_data_error();
      logic [31:0] d;
      wr(cspc_pkg::OFF_CTRL, 32'h7, 2'h0);
      cyc(3);
      check({initErrOe, initErrOut, initErrIn}, 3'h4, "error on init pin");
      check(irq, 1'h1, "error interrupt");
      rd(cspc_pkg::OFF_IRQ, 2'h0, d);
      check(d[2:0], 3'h6, "error and init-low status");
      wr(cspc_pkg::OFF_MASK, 32'h0, 2'h0);
      cyc(2);
      check(irq, 1'h0, "masked interrupt");
      wr(cspc_pkg::OFF_CTRL, 32'h3, 2'h0);
      wr(cspc_pkg::OFF_IRQ, 32'h7, 2'h0);
      rd(cspc_pkg::OFF_IRQ, 2'h0, d);
      check(d[2:0], 3'h0, "status cleared");
   endtask
   task automatic t_activate();
      int n;
      wr(cspc_pkg::OFF_MASK, 32'h7, 2'h0);
      wr(cspc_pkg::OFF_CTRL, 32'hb, 2'h0);
      for (n = 0; n < 20 && ioActive !== 1'h1; n++) @(posedge clk_sys);
      // First active cycle: user values 5a/a5 on bits 2..0
      check({highDuringConfigOut, highDuringConfigOe, lowDuringConfigOut, lowDuringConfigOe,
         initErrOut, initErrOe}, 6'h19, "release together");
      cyc(1);
      check(irq, 1'h1, "active interrupt");
      wr(cspc_pkg::OFF_IRQ, 32'h1, 2'h0);
      cyc(1);
      check(irq, 1'h0, "active cleared");
   endtask
   task automatic t_user_io();
      tdiPad <= 1'h1;
      tmsPad <= 1'h1;
      clockPairSrc <= 1'h1;
      cyc(2);
      check({ioOe, ioPullup}, 16'h05f0, "cells after active");
      check({scanEnable, testPinsToLogic}, 4'h5, "scan off, pads routed");
      check({lowSkewGlobalIn, earlyGlobalIn}, 2'h3, "buffer pair");
      wr(cspc_pkg::OFF_CTRL, 32'h1b, 2'h0);
      cyc(2);
      check({globalTristateNet, ioOe, ioActive}, 10'h201, "three-state");
      check(ioOut, 8'h5a, "logic runs under three-state");
      // Scan must stay on for the external test to override
      wr(cspc_pkg::OFF_CTRL, 32'hdb, 2'h0);
      cyc(2);
      check(ioOe, 8'h05, "external test override");
      wr(cspc_pkg::OFF_USER, 32'h303, 2'h0);
      wr(cspc_pkg::OFF_CTRL, 32'h34b, 2'h0);
      ioIn <= 8'h08;
      cyc(2);
      check({globalSetResetNet, globalTristateNet, scanEnable}, 3'h7, "nets from pin");
      check(ioOe, 8'h00, "three-state from pin");
      ioIn <= 8'h00;
      cyc(2);
      check({globalSetResetNet, globalTristateNet}, 2'h0, "reset pin low");
   endtask
   task automatic t_rereset();
      resetn <= 1'h0;
      cyc(2);
      resetn <= 1'h1;
      cyc(2);
      check({ioActive, highDuringConfigOe, initErrOe}, 3'h3, "second reset");
   endtask
   initial begin
      {awvalid, wvalid, bready, arvalid, rready, holdLow, tdiPad, tckPad, tmsPad} = 9'h0;
      {awaddr, araddr, ioIn, clockPairSrc} = 25'h0;
      {wdata, wstrb} = 36'hf;
      {userOut, userOe, ioUsed} = 24'h5aa50f;
      resetn = 1'h0;
      cyc(10);
      resetn <= 1'h1;
      t_preconfig();
      t_hold_wait();
      t_data_error();
      t_activate();
      t_user_io();
      t_rereset();
      give_verdict();
   end
   // Hang guard, well beyond the few thousand cycles needed
   initial begin
      #600000;
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
